// [logic/dpvw_seq.sv]
// Function
// - eight-bit wiper, sink current scales 255 minus code
// - wiper starts at mid-scale 128
// - serial-bus error forces wiper to 128
// - logic supply soft-starts for 0.5 ms right after load
// - boost enabled only with supply good and enable
// - gate pulse output low until ramp threshold
// - load copies stored wiper into volatile wiper
`timescale 1ns/100ps
`default_nettype none
module dpvw_seq #(
  parameter int unsigned LOAD_CYCLES = dpvw_pkg::LOAD_CYC,
  parameter int unsigned SOFT_CYCLES = dpvw_pkg::SOFT_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic vin_above_lockout, // comparator: input above lockout (async)
  input wire logic enable_pin, // enable input (async)
  input wire logic logic_supply_good, // logic rail in regulation (async)
  input wire logic ramp_above_thresh, // delay node above 1.215 V (async)
  input wire logic [7:0] nonvolatile_poweron_wiper, // stored wiper value
  input wire logic bus_error, // one-cycle serial-bus error pulse
  input wire logic wiper_wr, // one-cycle wiper write strobe
  input wire logic [7:0] wiper_wr_data, // wiper write data
  output logic logic_supply_rail_en, // logic LDO enable / soft-start
  output logic boost_output_rail_en, // boost converter enable
  output logic gate_pulse_output_en, // gate pulse output released
  output logic [7:0] wiper_q, // volatile wiper code
  output logic [7:0] sink_scale_q, // 255 minus code, sink current weight
  output logic settings_loaded_q // settings load complete
);

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, first stage read only by second

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end
    else
    begin
      meta_q <= {ramp_above_thresh, logic_supply_good, enable_pin, vin_above_lockout};
      sync_q <= meta_q;
    end
  end
  logic vin_ok;
  logic en_s;
  logic pg_s;
  logic ramp_s;
  assign vin_ok = sync_q[0];
  assign en_s = sync_q[1];
  assign pg_s = sync_q[2];
  assign ramp_s = sync_q[3];

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  dpvw_pkg::dpvw_state_e state_q;
  logic [dpvw_pkg::CNT_W-1:0] cnt_q;
  logic load_done;
  logic soft_done;
  assign load_done = (cnt_q == dpvw_pkg::CNT_W'(LOAD_CYCLES - 1));
  assign soft_done = (cnt_q == dpvw_pkg::CNT_W'(SOFT_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= dpvw_pkg::DPVW_OFF;
      cnt_q <= '0;
    end
    else if (!vin_ok)
    begin
      state_q <= dpvw_pkg::DPVW_OFF;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        dpvw_pkg::DPVW_OFF:
        begin
          state_q <= dpvw_pkg::DPVW_LOAD;
          cnt_q <= '0;
        end
        dpvw_pkg::DPVW_LOAD:
        begin
          if (load_done)
          begin
            state_q <= dpvw_pkg::DPVW_SOFT;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        dpvw_pkg::DPVW_SOFT:
        begin
          if (soft_done)
          begin
            state_q <= dpvw_pkg::DPVW_RUN;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        dpvw_pkg::DPVW_RUN:
          cnt_q <= '0;
        default:
          state_q <= dpvw_pkg::DPVW_OFF;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settings_loaded_q <= 1'b0;
    else if (!vin_ok)
      settings_loaded_q <= 1'b0;
    else if (state_q == dpvw_pkg::DPVW_LOAD && load_done)
      settings_loaded_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // rail enables, all registered

  dpvw_pkg::dpvw_rails_s rails_q;
  logic ldo_on;
  assign ldo_on = vin_ok && (state_q == dpvw_pkg::DPVW_SOFT || state_q == dpvw_pkg::DPVW_RUN);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rails_q <= '0;
    else
    begin
      rails_q.logic_en <= ldo_on;
      // pg alone is not trusted until the ldo has finished soft-start
      rails_q.boost_en <= vin_ok && (state_q == dpvw_pkg::DPVW_RUN) && pg_s && en_s;
      // gate release follows the boost; it falls one cycle after the synced ramp drops
      rails_q.gate_rel <= vin_ok && rails_q.boost_en && ramp_s;
    end
  end
  assign logic_supply_rail_en = rails_q.logic_en;
  assign boost_output_rail_en = rails_q.boost_en;
  assign gate_pulse_output_en = rails_q.gate_rel;

  ////////////////////////////////////////////////////////////////////////
  // wiper

  // one next-value path feeds both the code and its sink weight,
  // so the two registers can never drift apart for a cycle
  // priority: bus error, then the power-up copy, then a plain write
  logic [7:0] wiper_d;
  always_comb
  begin
    wiper_d = wiper_q;
    if (bus_error)
      wiper_d = dpvw_pkg::WIPER_MID;
    else if (state_q == dpvw_pkg::DPVW_LOAD && load_done && vin_ok)
      wiper_d = nonvolatile_poweron_wiper;
    else if (wiper_wr)
      wiper_d = wiper_wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wiper_q <= dpvw_pkg::WIPER_MID;
    else
      wiper_q <= wiper_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sink_scale_q <= dpvw_pkg::WIPER_FULL - dpvw_pkg::WIPER_MID;
    else
      sink_scale_q <= dpvw_pkg::WIPER_FULL - wiper_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  load_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state_q == dpvw_pkg::DPVW_SOFT) |-> $past(state_q == dpvw_pkg::DPVW_LOAD))
    else $error("soft-start entered without load");
  ldo_after_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    logic_supply_rail_en |-> settings_loaded_q || !vin_ok || $past(!vin_ok))
    else $error("logic rail on before settings loaded");
  boost_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    boost_output_rail_en |-> $past(pg_s && en_s))
    else $error("boost on without supply good and enable");
  gate_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    gate_pulse_output_en |-> $past(ramp_s) && $past(boost_output_rail_en))
    else $error("gate output released early");
  err_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus_error |=> wiper_q == 8'h80)
    else $error("wiper not reset to mid on bus error");
  load_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == dpvw_pkg::DPVW_LOAD && load_done && vin_ok && !bus_error)
    |=> wiper_q == $past(nonvolatile_poweron_wiper))
    else $error("stored wiper not copied");
  scale_lin_a: assert property (@(posedge clk) disable iff (!rst_n)
    sink_scale_q == 8'hff - wiper_q)
    else $error("sink scale not 255 minus code");
  lockout_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !vin_ok |=> state_q == dpvw_pkg::DPVW_OFF && !settings_loaded_q && !boost_output_rail_en)
    else $error("lockout did not reset sequence");
  soft_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state_q == dpvw_pkg::DPVW_RUN) |-> $past(soft_done))
    else $error("soft-start length wrong");

  run_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(state_q == dpvw_pkg::DPVW_RUN));
  boost_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(boost_output_rail_en));
  gate_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(gate_pulse_output_en));
  err_c: cover property (@(posedge clk) disable iff (!rst_n) bus_error && wiper_q != 8'h80);

endmodule
`default_nettype wire

// [shared/dpvw_pkg.sv]
`default_nettype none
package dpvw_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned WIPER_W = 8;
  localparam logic [7:0] WIPER_MID = 8'h80;
  localparam logic [7:0] WIPER_FULL = 8'hff;
  // settings load time in ns, soft-start time in ns
  localparam int unsigned LOAD_NS = 120000;
  localparam int unsigned SOFT_NS = 500000;
  localparam int unsigned LOAD_CYC = (LOAD_NS * 40 + 999) / 1000;
  localparam int unsigned SOFT_CYC = (SOFT_NS * 40 + 999) / 1000;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [2:0] {
    DPVW_OFF,
    DPVW_LOAD,
    DPVW_SOFT,
    DPVW_RUN
  } dpvw_state_e;

  typedef struct packed {
    logic logic_en;
    logic boost_en;
    logic gate_rel;
  } dpvw_rails_s;
endpackage
`default_nettype wire

// [test/dpvw_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dpvw_host_model (
  input wire logic clk, // system clock
  input wire logic wr_req, // bench asks for a write
  input wire logic err_req, // bench asks for a failed transfer
  input wire logic [7:0] wr_val, // value to write
  output logic wiper_wr, // write strobe
  output logic [7:0] wiper_wr_data, // write data
  output logic bus_error // error pulse
);
  // data flips when idle so nothing can lean on a stale value
  always_ff @(posedge clk)
  begin
    wiper_wr <= wr_req;
    bus_error <= err_req;
    wiper_wr_data <= wr_req ? wr_val : ~wiper_wr_data;
  end
endmodule
`default_nettype wire

// [test/dpvw_seq_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module dpvw_seq_tb_top;
  localparam int LD = 8;
  localparam int SF = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vin = 1'b0, en = 1'b1, pg = 1'b1, ramp = 1'b0, wr_req = 1'b0, err_req = 1'b0;
  logic [7:0] nv = 8'h3c, wr_val = 8'h00, wdat, wq, sq;
  logic wr, berr, ldo, bst, gate, lded;
  int miscompares = 0, check_count = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  dpvw_host_model host_u (.clk(clk), .wr_req(wr_req), .err_req(err_req), .wr_val(wr_val),
    .wiper_wr(wr), .wiper_wr_data(wdat), .bus_error(berr));
  dpvw_seq #(.LOAD_CYCLES(LD), .SOFT_CYCLES(SF)) dut_u (.clk(clk), .rst_n(rst_n),
    .vin_above_lockout(vin), .enable_pin(en), .logic_supply_good(pg),
    .ramp_above_thresh(ramp), .nonvolatile_poweron_wiper(nv), .bus_error(berr),
    .wiper_wr(wr), .wiper_wr_data(wdat), .logic_supply_rail_en(ldo),
    .boost_output_rail_en(bst), .gate_pulse_output_en(gate), .wiper_q(wq),
    .sink_scale_q(sq), .settings_loaded_q(lded));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_load();
    logic early;
    early = 1'b0;
    for (n = 0; n < 100 && lded !== 1'b1; n++)
    begin
      if (ldo !== 1'b0) early = 1'b1;
      tick(1);
    end
    `CHK("ldo_early", 1'b0, early)
    `CHK("loaded", 1'b1, lded)
    // two sync stages and one idle state come before the load count
    `CHK("load_len", LD + 3, n)
  endtask
  task automatic bus(input logic w, input logic e, input logic [7:0] v);
    @(posedge clk);
    wr_req <= w;
    err_req <= e;
    wr_val <= v;
    @(posedge clk);
    wr_req <= 1'b0;
    err_req <= 1'b0;
    tick(2);
  endtask
  task automatic t_powerup();
    @(posedge clk) vin <= 1'b1;
    wait_load();
    `CHK("wiper_load", 8'h3c, wq)
    `CHK("scale_load", 8'hc3, sq)
    tick(1);
    `CHK("ldo_on", 1'b1, ldo)
    tick(SF - 4);
    `CHK("boost_soft", 1'b0, bst)
    tick(8);
    `CHK("boost_on", 1'b1, bst)
    `CHK("gate_low", 1'b0, gate)
    @(posedge clk) ramp <= 1'b1;
    tick(5);
    `CHK("gate_rel", 1'b1, gate)
    @(posedge clk) pg <= 1'b0;
    tick(5);
    `CHK("boost_pg", 1'b0, bst)
    @(posedge clk) pg <= 1'b1;
    tick(5);
    @(posedge clk) en <= 1'b0;
    tick(5);
    `CHK("boost_en", 1'b0, bst)
    @(posedge clk) en <= 1'b1;
    tick(5);
    $display("test powerup done");
  endtask
  task automatic t_wiper();
    bus(1'b1, 1'b0, 8'hff);
    `CHK("scale_ff", 8'h00, sq)
    bus(1'b1, 1'b0, 8'h00);
    `CHK("scale_00", 8'hff, sq)
    bus(1'b0, 1'b1, 8'h00);
    `CHK("wiper_err", 8'h80, wq)
    `CHK("scale_err", 8'h7f, sq)
    bus(1'b1, 1'b0, 8'h11);
    `CHK("wiper_wr", 8'h11, wq)
    bus(1'b1, 1'b1, 8'h22);
    `CHK("wiper_err_wr", 8'h80, wq)
    $display("test wiper done");
  endtask
  task automatic t_lockout();
    @(posedge clk) vin <= 1'b0;
    tick(6);
    `CHK("rails_off", 3'b000, {ldo, bst, gate})
    `CHK("loaded_clr", 1'b0, lded)
    @(posedge clk)
    begin
      nv <= 8'h5a;
      vin <= 1'b1;
    end
    wait_load();
    `CHK("wiper_reload", 8'h5a, wq)
    $display("test lockout done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ceiling is well above the hundred-odd cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    tick(10);
    `CHK("wiper_rst", 8'h80, wq)
    `CHK("scale_rst", 8'h7f, sq)
    @(posedge clk) rst_n <= 1'b1;
    tick(3);
    t_powerup();
    t_wiper();
    t_lockout();
    tally_and_finish();
  end
endmodule
`default_nettype wire
